// >>> common/wdrs_cfg.svh
// Constants of the watchdog and reset-source block: register offsets,
// field positions, reset values and timing counts.
// Assumes a 100 MHz CPU clock; one half-clock period is half a cycle.
`ifndef WDRS_CFG_SVH
`define WDRS_CFG_SVH

// Register byte offsets
`define WDRS_OFS_CTRL 6'h00
`define WDRS_OFS_CMD 6'h04
`define WDRS_OFS_COUNT 6'h08
`define WDRS_OFS_SYSCFG 6'h0C
`define WDRS_OFS_IRQ_STAT 6'h10
`define WDRS_OFS_IRQ_MASK 6'h14

// Control register fields
`define WDRS_CTRL_PSCL_BIT 0
`define WDRS_CTRL_FLAG_LSB 1
`define WDRS_CTRL_RELOAD_LSB 8

// Command register bits
`define WDRS_CMD_SERVICE 0
`define WDRS_CMD_DISABLE 1
`define WDRS_CMD_END_INIT 2
`define WDRS_CMD_SW_RESET 3

// Interrupt event bits
`define WDRS_EV_OVERFLOW 0
`define WDRS_EV_SOFTWARE 1
`define WDRS_EV_HARDWARE 2

// Reset values and counter maximum
`define WDRS_RELOAD_RST 8'h00
`define WDRS_COUNT_RST 16'h0000
`define WDRS_COUNT_MAX 16'hFFFF

// Prescaler divisors
`define WDRS_DIV_LOW 2
`define WDRS_DIV_HIGH 128

// Timing: clock rate and figures in half-clock periods or ns
`define WDRS_CLK_MHZ 100
`define WDRS_PRE_TCL 12
`define WDRS_SEQ_TCL 1024
`define WDRS_SMP_TCL 8
`define WDRS_PRE_CYC ((`WDRS_PRE_TCL + 1) / 2)
`define WDRS_SEQ_CYC ((`WDRS_SEQ_TCL + 1) / 2)
`define WDRS_SMP_CYC ((`WDRS_SMP_TCL + 1) / 2)
`define WDRS_FILT_NS 500
`define WDRS_FILT_CYC ((`WDRS_FILT_NS * `WDRS_CLK_MHZ) / 1000)

`endif

// >>> common/wdrs_pkg.sv
// Types of the watchdog and reset-source block.
// Assumes wdrs_cfg.svh supplies all numeric constants.
package wdrs_pkg;

    typedef enum logic [2:0] {
        ST_RUN,
        ST_PRE,
        ST_SEQ,
        ST_SAMPLE,
        ST_HOLD,
        ST_ASYNC
    } wdrs_state_t;

    typedef enum logic [1:0] {
        CAUSE_HW,
        CAUSE_WDT,
        CAUSE_SW
    } wdrs_cause_t;

    // Reset-source flags, high bit first in the control register
    typedef struct packed {
        logic power_on_flag;
        logic long_hardware_flag;
        logic short_hardware_flag;
        logic watchdog_overflow_flag;
        logic software_flag;
    } wdrs_flags_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic [5:0] cnt;
        logic low;
    } wdrs_filt_t;

    typedef struct packed {
        wdrs_state_t state;
        wdrs_cause_t cause;
        logic [9:0] seq_cnt;
        logic [6:0] pscl;
        logic [15:0] count;
        logic [7:0] reload;
        logic pscl_sel;
        logic running;
        logic init_done;
        wdrs_flags_t flags;
        logic bidir_en;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic ap_valid;
        logic ap_write;
        logic [5:0] ap_addr;
        logic [31:0] hrdata;
        logic mode_s1;
        logic mode_s2;
    } wdrs_core_t;

endpackage

// >>> verilog/wdrs_rst_filter.sv
// Reset-input filter: synchroniser and low-pulse width qualifier.
// Assumes the raw pin is asynchronous to clk.
`timescale 1ns/100ps
`include "wdrs_cfg.svh"

module wdrs_rst_filter (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Raw pin, active low
    input wire logic pin_n,
    // Qualified low level
    output logic low
);

    wdrs_pkg::wdrs_filt_t r_reg;
    wdrs_pkg::wdrs_filt_t r_next;

    localparam logic [5:0] FILT_LAST = 6'(`WDRS_FILT_CYC - 1);

    // Low must persist the full window; spikes restart the count
    always_comb begin
        r_next = r_reg;
        r_next.s1 = pin_n;
        r_next.s2 = r_reg.s1;
        if (r_reg.s2) begin
            r_next.cnt = 6'h00;
            r_next.low = 1'b0;
        end else if (r_reg.cnt == FILT_LAST) begin
            r_next.low = 1'b1;
        end else begin
            r_next.cnt = r_reg.cnt + 6'h01;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            r_reg <= '{s1: 1'b1, s2: 1'b1, cnt: 6'h00, low: 1'b0};
        end else begin
            r_reg <= r_next;
        end
    end

    assign low = r_reg.low;

endmodule

// >>> verilog/wdrs_core.sv
// Watchdog timer and reset-source logic with an AHB-Lite register slave.
// Assumes one 100 MHz clock, word-only single transfers, and that
// reset_input_pin and reset_mode_pin are asynchronous pins.
//
// The AHB-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`include "wdrs_cfg.svh"

module wdrs_core (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Reset pins
    input wire logic reset_input_pin_n_in,
    output logic reset_input_pin_n_out,
    output logic reset_input_pin_n_oe,
    input wire logic reset_mode_pin,
    output logic reset_output_pin_n,
    // Internal reset and interrupt
    output logic core_reset,
    output logic irq
);

    wdrs_pkg::wdrs_core_t r_reg;
    wdrs_pkg::wdrs_core_t r_next;

    logic pin_low;
    logic take;
    logic wr;
    logic tick;
    logic ovf;
    logic [2:0] ev;
    logic [2:0] stat_clr;
    logic [6:0] pscl_last;

    localparam logic [9:0] PRE_LAST = 10'(`WDRS_PRE_CYC - 1);
    localparam logic [9:0] SEQ_LAST = 10'(`WDRS_SEQ_CYC - 1);
    localparam logic [9:0] SMP_LAST = 10'(`WDRS_SMP_CYC - 1);
    localparam logic [6:0] DIV_LOW_LAST = 7'(`WDRS_DIV_LOW - 1);
    localparam logic [6:0] DIV_HIGH_LAST = 7'(`WDRS_DIV_HIGH - 1);

    // Register decode shared by read and write paths
    function automatic logic is_reg(input logic [5:0] a,
                                    input logic [5:0] ofs);
        is_reg = (a[5:2] == ofs[5:2]);
    endfunction

    // Read data for a word address
    function automatic logic [31:0] rd_word(
        input wdrs_pkg::wdrs_core_t s, input logic [5:0] a);
        rd_word = 32'h0000_0000;
        if (is_reg(a, `WDRS_OFS_CTRL)) begin
            rd_word[`WDRS_CTRL_PSCL_BIT] = s.pscl_sel;
            rd_word[`WDRS_CTRL_FLAG_LSB +: 5] = s.flags;
            rd_word[`WDRS_CTRL_RELOAD_LSB +: 8] = s.reload;
        end else if (is_reg(a, `WDRS_OFS_COUNT)) begin
            rd_word[15:0] = s.count;
            rd_word[16] = s.running;
            rd_word[17] = s.init_done;
        end else if (is_reg(a, `WDRS_OFS_SYSCFG)) begin
            rd_word[0] = s.bidir_en;
        end else if (is_reg(a, `WDRS_OFS_IRQ_STAT)) begin
            rd_word[2:0] = s.irq_stat;
        end else if (is_reg(a, `WDRS_OFS_IRQ_MASK)) begin
            rd_word[2:0] = s.irq_mask;
        end
    endfunction

    // Reset-input filter
    wdrs_rst_filter u_filter (
        .clk(clk),
        .sys_rst(sys_rst),
        .pin_n(reset_input_pin_n_in),
        .low(pin_low)
    );

    // Bus handshake and watchdog tick
    always_comb begin
        take = hsel && htrans[1] && hready;
        wr = r_reg.ap_valid && r_reg.ap_write &&
             (r_reg.state == wdrs_pkg::ST_RUN);
        pscl_last = r_reg.pscl_sel ? DIV_HIGH_LAST : DIV_LOW_LAST;
        tick = r_reg.running && (r_reg.state == wdrs_pkg::ST_RUN) &&
               (r_reg.pscl == pscl_last);
        ovf = tick && (r_reg.count == `WDRS_COUNT_MAX);
    end

    // Next state of the whole block
    always_comb begin
        r_next = r_reg;
        ev = 3'b000;
        stat_clr = 3'b000;

        // Mode pin synchroniser
        r_next.mode_s1 = reset_mode_pin;
        r_next.mode_s2 = r_reg.mode_s1;

        // Address phase capture; read data prepared now for zero wait
        r_next.ap_valid = take;
        r_next.ap_write = hwrite;
        r_next.ap_addr = haddr[5:0];
        if (take && !hwrite) begin
            r_next.hrdata = rd_word(r_reg, haddr[5:0]);
            if (is_reg(haddr[5:0], `WDRS_OFS_IRQ_STAT)) begin
                stat_clr = r_reg.irq_stat;
            end
        end

        unique case (r_reg.state)
            wdrs_pkg::ST_RUN: begin
                // Prescaler and up-counter
                if (r_reg.running) begin
                    r_next.pscl = tick ? 7'h00 : r_reg.pscl + 7'h01;
                    if (tick) begin
                        r_next.count = r_reg.count + 16'h0001;
                    end
                end

                // Register writes from the data phase
                if (wr && is_reg(r_reg.ap_addr, `WDRS_OFS_CTRL)) begin
                    r_next.pscl_sel = hwdata[`WDRS_CTRL_PSCL_BIT];
                    r_next.reload = hwdata[`WDRS_CTRL_RELOAD_LSB +: 8];
                end
                if (wr && is_reg(r_reg.ap_addr, `WDRS_OFS_SYSCFG)) begin
                    r_next.bidir_en = hwdata[0];
                end
                if (wr && is_reg(r_reg.ap_addr, `WDRS_OFS_IRQ_MASK)) begin
                    r_next.irq_mask = hwdata[2:0];
                end
                if (wr && is_reg(r_reg.ap_addr, `WDRS_OFS_CMD)) begin
                    // Service restarts the period from the reload value
                    if (hwdata[`WDRS_CMD_SERVICE]) begin
                        r_next.count = {r_reg.reload, 8'h00};
                        r_next.pscl = 7'h00;
                    end
                    // Disable is locked once initialisation has ended
                    if (hwdata[`WDRS_CMD_DISABLE] && !r_reg.init_done) begin
                        r_next.running = 1'b0;
                    end
                    if (hwdata[`WDRS_CMD_END_INIT]) begin
                        r_next.init_done = 1'b1;
                        r_next.flags = '0;
                    end
                end

                // Reset sources, pin first since it may be a power fault
                if (pin_low && !r_reg.mode_s2) begin
                    r_next.state = wdrs_pkg::ST_ASYNC;
                    ev[`WDRS_EV_HARDWARE] = 1'b1;
                end else if (pin_low) begin
                    r_next.state = wdrs_pkg::ST_PRE;
                    r_next.cause = wdrs_pkg::CAUSE_HW;
                    ev[`WDRS_EV_HARDWARE] = 1'b1;
                end else if (ovf) begin
                    r_next.state = wdrs_pkg::ST_PRE;
                    r_next.cause = wdrs_pkg::CAUSE_WDT;
                    r_next.flags.watchdog_overflow_flag = 1'b1;
                    ev[`WDRS_EV_OVERFLOW] = 1'b1;
                end else if (wr && is_reg(r_reg.ap_addr, `WDRS_OFS_CMD) &&
                             hwdata[`WDRS_CMD_SW_RESET]) begin
                    r_next.state = wdrs_pkg::ST_PRE;
                    r_next.cause = wdrs_pkg::CAUSE_SW;
                    r_next.flags.software_flag = 1'b1;
                    ev[`WDRS_EV_SOFTWARE] = 1'b1;
                end
                r_next.seq_cnt = 10'h000;
            end

            // Pending reads are allowed to finish; writes are no longer taken
            wdrs_pkg::ST_PRE: begin
                r_next.seq_cnt = r_reg.seq_cnt + 10'h001;
                if (r_reg.seq_cnt == PRE_LAST) begin
                    r_next.state = wdrs_pkg::ST_SEQ;
                    r_next.seq_cnt = 10'h000;
                end
            end

            // Internal reset sequence
            wdrs_pkg::ST_SEQ: begin
                r_next.seq_cnt = r_reg.seq_cnt + 10'h001;
                if (r_reg.seq_cnt == SEQ_LAST) begin
                    r_next.state = wdrs_pkg::ST_SAMPLE;
                    r_next.seq_cnt = 10'h000;
                end
            end

            // Filtered pin sampled at the end of the extra window
            wdrs_pkg::ST_SAMPLE: begin
                r_next.seq_cnt = r_reg.seq_cnt + 10'h001;
                if (r_reg.seq_cnt == SMP_LAST) begin
                    r_next.state = wdrs_pkg::ST_HOLD;
                    r_next.bidir_en = 1'b0;
                    if (r_reg.cause == wdrs_pkg::CAUSE_HW) begin
                        r_next.flags.short_hardware_flag = 1'b1;
                        if (pin_low) begin
                            r_next.flags.long_hardware_flag = 1'b1;
                        end
                    end
                end
            end

            // Stay in reset while the pin is still held low
            wdrs_pkg::ST_HOLD: begin
                if (!pin_low) begin
                    r_next.state = wdrs_pkg::ST_RUN;
                end
            end

            // Asynchronous reset follows the pin directly
            wdrs_pkg::ST_ASYNC: begin
                r_next.bidir_en = 1'b0;
                if (!pin_low) begin
                    r_next.state = wdrs_pkg::ST_RUN;
                end
            end
        endcase

        // Leaving reset always restarts a running watchdog
        if (r_reg.state != wdrs_pkg::ST_RUN &&
            r_next.state == wdrs_pkg::ST_RUN) begin
            r_next.running = 1'b1;
            r_next.init_done = 1'b0;
            r_next.count = `WDRS_COUNT_RST;
            r_next.pscl = 7'h00;
            r_next.reload = `WDRS_RELOAD_RST;
            r_next.pscl_sel = 1'b0;
        end

        // Sticky events; a new event beats a read clear
        r_next.irq_stat = (r_reg.irq_stat & ~stat_clr) | ev;
    end

    // State register; power-on marks its own flag
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            r_reg <= '{
                state: wdrs_pkg::ST_RUN,
                cause: wdrs_pkg::CAUSE_HW,
                seq_cnt: 10'h000,
                pscl: 7'h00,
                count: `WDRS_COUNT_RST,
                reload: `WDRS_RELOAD_RST,
                pscl_sel: 1'b0,
                running: 1'b1,
                init_done: 1'b0,
                flags: 5'h10,
                bidir_en: 1'b0,
                irq_stat: 3'h0,
                irq_mask: 3'h0,
                ap_valid: 1'b0,
                ap_write: 1'b0,
                ap_addr: 6'h00,
                hrdata: 32'h0000_0000,
                mode_s1: 1'b0,
                mode_s2: 1'b0
            };
        end else begin
            r_reg <= r_next;
        end
    end

    // Bus answers: always ready, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = r_reg.hrdata;

    // Reset outputs follow the sequencer state
    assign core_reset = (r_reg.state != wdrs_pkg::ST_RUN);
    assign reset_output_pin_n = (r_reg.state == wdrs_pkg::ST_RUN);

    // Pull the reset input low on internal resets, unless mode pin is low
    assign reset_input_pin_n_out = 1'b0;
    assign reset_input_pin_n_oe = r_reg.bidir_en && r_reg.mode_s2 &&
        (r_reg.cause != wdrs_pkg::CAUSE_HW) &&
        (r_reg.state == wdrs_pkg::ST_PRE ||
         r_reg.state == wdrs_pkg::ST_SEQ ||
         r_reg.state == wdrs_pkg::ST_SAMPLE);

    // Level interrupt from unmasked sticky events
    assign irq = |(r_reg.irq_stat & r_reg.irq_mask);

endmodule

// >>> dv/wdrs_pin_model.sv
// External reset circuitry: pull-up on the reset input pin, open drain.
// Assumes the bench asks for a low level by hold_low.
`timescale 1ns/100ps
module wdrs_pin_model (
    // Requests
    input wire logic hold_low,
    input wire logic drive_oe,
    input wire logic drive_val,
    // Wire level seen by the block
    output logic pin_n
);
    // Wired AND of both drivers; pull-up wins when nobody pulls
    assign pin_n = (hold_low || (drive_oe && !drive_val)) ? 1'b0 : 1'b1;
endmodule

// >>> dv/wdrs_monitor.sv
// Checker for the watchdog and reset-source block.
// Assumes it is bound to wdrs_core and sees only its ports.
`timescale 1ns/100ps
`include "wdrs_cfg.svh"
module wdrs_monitor (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // Pins and internal reset
    input wire logic reset_input_pin_n_in,
    input wire logic reset_input_pin_n_out,
    input wire logic reset_input_pin_n_oe,
    input wire logic reset_mode_pin,
    input wire logic reset_output_pin_n,
    input wire logic core_reset,
    input wire logic irq
);
    logic [10:0] rst_len;
    logic [6:0] low_cnt;
    logic take;
    // Length of internal reset and of raw low level; low count saturates
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rst_len <= 11'h000;
            low_cnt <= 7'h00;
        end else begin
            rst_len <= core_reset ? rst_len + 11'h001 : 11'h000;
            if (reset_input_pin_n_in)
                low_cnt <= 7'h00;
            else if (low_cnt != 7'h7F)
                low_cnt <= low_cnt + 7'h01;
        end
    end
    assign take = hsel && htrans[1] && hready;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_out_pin_level: assert property (
        reset_output_pin_n == !core_reset) else $error("reset pin mismatch");
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus response not okay");
    a_oe_in_reset: assert property (
        reset_input_pin_n_oe |-> core_reset && !reset_input_pin_n_out)
        else $error("pin driven outside reset");
    a_oe_mode_low: assert property (
        (!reset_mode_pin) [*6] |-> !reset_input_pin_n_oe)
        else $error("pin driven with mode low");
    a_seq_full: assert property (
        $fell(core_reset) |-> rst_len >= 11'h20A)
        else $error("reset sequence too short");
    a_pin_held: assert property (
        low_cnt >= 7'h3C |-> core_reset) else $error("long low not seen");
    a_swreset_next: assert property (
        $past(take && hwrite && haddr[5:0] == `WDRS_OFS_CMD) && hwdata[3]
        && !core_reset && reset_input_pin_n_in |=> core_reset)
        else $error("software reset missed");
    a_empty_read: assert property (
        take && !hwrite && (haddr[5:0] == 6'h18 ||
        haddr[5:0] == `WDRS_OFS_CMD) |=> hrdata == 32'h00000000)
        else $error("empty place read nonzero");
    a_reset_idle: assert property (disable iff (1'b0)
        sys_rst |=> !core_reset && reset_output_pin_n && !irq
        && !reset_input_pin_n_oe && hrdata == 32'h00000000)
        else $error("outputs not idle in reset");
    c_reset: cover property ($rose(core_reset));
    c_drive: cover property (reset_input_pin_n_oe);
    c_irq: cover property (irq);
    c_long: cover property ($fell(core_reset) && rst_len > 11'h258);
endmodule

bind wdrs_core wdrs_monitor u_mon (.clk(clk), .sys_rst(sys_rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .reset_input_pin_n_in(reset_input_pin_n_in),
    .reset_input_pin_n_out(reset_input_pin_n_out),
    .reset_input_pin_n_oe(reset_input_pin_n_oe),
    .reset_mode_pin(reset_mode_pin), .reset_output_pin_n(reset_output_pin_n),
    .core_reset(core_reset), .irq(irq));

// >>> dv/wdrs_core_tb_top.sv
// Self-checking bench for wdrs_core: bus tasks, pin model, reset checks.
// Assumes the checker is bound from its own file; hsize is tied to word.
`timescale 1ns/100ps
`include "wdrs_cfg.svh"
module wdrs_core_tb_top;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h00000000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h00000000;
    logic ext_low = 1'b0;
    logic mode = 1'b1;
    logic hready, hresp, pin_n, pin_out, pin_oe, rst_out_n, core_reset, irq;
    logic [31:0] hrdata, rd;
    logic seen;
    int miscompares = 0;
    int tests_run = 0;
    int cyc = 0;
    int t0, len, div;

    wdrs_core uut (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
        .reset_input_pin_n_in(pin_n), .reset_input_pin_n_out(pin_out),
        .reset_input_pin_n_oe(pin_oe), .reset_mode_pin(mode),
        .reset_output_pin_n(rst_out_n), .core_reset(core_reset), .irq(irq));
    wdrs_pin_model pins (.hold_low(ext_low), .drive_oe(pin_oe),
        .drive_val(pin_out), .pin_n(pin_n));

    // Clock and hang guard; ceiling covers the slow prescaler run
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            miscompares++;
            final_report();
        end
    end

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // One single transfer; no wait states assumed, hready still honoured
    task automatic bus(input logic [31:0] a, input logic w,
                       input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic chk_rng(input int got, input int lo, input int hi);
        tests_run++;
        if (got < lo || got > hi) begin
            miscompares++;
            $display("wrong value at %0t: count %0d", $time, got);
        end
    endtask

    task automatic rdchk(input logic [31:0] a, input logic [31:0] m,
                         input logic [31:0] e);
        bus(a, 1'b0, 32'h00000000);
        chk_val(rd & m, e);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
    endtask

    // Wait for core_reset to reach lvl; len counts cycles, seen notes oe
    task automatic wait_lvl(input logic lvl, input int lim);
        len = 0;
        seen = 1'b0;
        while (core_reset !== lvl && len < lim) begin
            tick(1);
            len++;
            seen |= pin_oe;
        end
    endtask

    // Control rewritten before every service: reload 00, low prescaler
    task automatic calm();
        wr(`WDRS_OFS_CTRL, 32'h00000000);
        wr(`WDRS_OFS_CMD, 32'h00000001);
    endtask

    initial begin
        tick(4);
        sys_rst <= 1'b0;
        rdchk(`WDRS_OFS_CTRL, 32'h0000FFFF, 32'h00000020);
        rdchk(`WDRS_OFS_SYSCFG, 32'h00000001, 32'h00000000);
        rdchk(`WDRS_OFS_COUNT, 32'h00030000, 32'h00010000);
        rdchk(32'h00000018, 32'hFFFFFFFF, 32'h00000000);
        rdchk(`WDRS_OFS_CMD, 32'hFFFFFFFF, 32'h00000000);
        $display("test reset_values done");
        // Overflow at both prescaler settings, reload FF
        wr(`WDRS_OFS_IRQ_MASK, 32'h00000001);
        for (int p = 0; p < 2; p++) begin
            div = p ? `WDRS_DIV_HIGH : `WDRS_DIV_LOW;
            wr(`WDRS_OFS_CTRL, {16'h0000, 8'hFF, 7'h00, p[0]});
            wr(`WDRS_OFS_CMD, 32'h00000001);
            #1 t0 = cyc;
            rdchk(`WDRS_OFS_COUNT, 32'h0000FF00, 32'h0000FF00);
            wait_lvl(1'b1, 40000);
            chk_rng(cyc - t0, 256 * div - 2, 256 * div + 4);
            chk_val({31'h0, irq}, 32'h00000001);
            wait_lvl(1'b0, 2000);
            chk_rng(len, 522, 526);
            rdchk(`WDRS_OFS_CTRL, 32'h00000004, 32'h00000004);
            rdchk(`WDRS_OFS_IRQ_STAT, 32'h00000001, 32'h00000001);
            chk_val({31'h0, irq}, 32'h00000000);
            calm();
        end
        $display("test overflow done");
        wr(`WDRS_OFS_CMD, 32'h00000004);
        rdchk(`WDRS_OFS_CTRL, 32'h0000003E, 32'h00000000);
        wr(`WDRS_OFS_CMD, 32'h00000002);
        rdchk(`WDRS_OFS_COUNT, 32'h00030000, 32'h00030000);
        $display("test end_of_init done");
        // Software reset with bidirectional drive, mode high then low
        for (int m = 1; m >= 0; m--) begin
            wr(`WDRS_OFS_SYSCFG, 32'h00000001);
            mode <= m[0];
            tick(4);
            wr(`WDRS_OFS_CMD, 32'h00000008);
            wait_lvl(1'b1, 4);
            chk_rng(len, 0, 1);
            wait_lvl(1'b0, 2000);
            chk_rng(len, 522, 526);
            chk_val({31'h0, seen}, {31'h0, m[0]});
            mode <= 1'b1;
            rdchk(`WDRS_OFS_CTRL, 32'h00000002, 32'h00000002);
            rdchk(`WDRS_OFS_SYSCFG, 32'h00000001, 32'h00000000);
            rdchk(`WDRS_OFS_IRQ_STAT, 32'h00000002, 32'h00000002);
            rdchk(`WDRS_OFS_COUNT, 32'h00030000, 32'h00010000);
            calm();
        end
        wr(`WDRS_OFS_CMD, 32'h00000002);
        rdchk(`WDRS_OFS_COUNT, 32'h00010000, 32'h00000000);
        $display("test software_reset done");
        // Pin pulses: spike, short, long, then asynchronous
        ext_low <= 1'b1;
        tick(3);
        ext_low <= 1'b0;
        wait_lvl(1'b1, 100);
        chk_rng(len, 100, 100);
        ext_low <= 1'b1;
        wait_lvl(1'b1, 100);
        chk_rng(len, 48, 60);
        tick(10);
        ext_low <= 1'b0;
        wait_lvl(1'b0, 2000);
        rdchk(`WDRS_OFS_CTRL, 32'h00000018, 32'h00000008);
        wr(`WDRS_OFS_CMD, 32'h00000004);
        ext_low <= 1'b1;
        wait_lvl(1'b1, 100);
        tick(700);
        ext_low <= 1'b0;
        wait_lvl(1'b0, 2000);
        rdchk(`WDRS_OFS_CTRL, 32'h00000018, 32'h00000018);
        wr(`WDRS_OFS_CMD, 32'h00000004);
        mode <= 1'b0;
        tick(4);
        ext_low <= 1'b1;
        wait_lvl(1'b1, 100);
        tick(600);
        ext_low <= 1'b0;
        wait_lvl(1'b0, 200);
        chk_rng(len, 1, 199);
        mode <= 1'b1;
        rdchk(`WDRS_OFS_CTRL, 32'h0000003E, 32'h00000000);
        $display("test pin_resets done");
        final_report();
    end
endmodule
